// >>> src/rcs_pkg.sv
package rcs_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_PER_S = 1000;
	// Power-up timer delay in ms and in clock cycles
	localparam int POWER_UP_TIMER_MS = 64;
	localparam int POWER_UP_TIMER_CYC = POWER_UP_TIMER_MS * (CLK_HZ / MS_PER_S);
	// Oscillator start-up timer
	localparam int OST_W = 10;
	localparam int OST_PERIODS = 1024;
	localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_PERIODS - 1);
	localparam int TMR_W = 32;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_OSC = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CLOCK_FAIL_MONITOR = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h0C;
	// Configuration word fields
	localparam int CFG_W = 8;
	localparam int CFG_CSW = 0;
	localparam int CFG_SEL_LSB = 1;
	localparam int CFG_PM_LSB = 4;
	localparam int CFG_POWER_UP_TIMER = 6;
	localparam int CFG_TWO = 7;
	localparam logic [CFG_W-1:0] CFG_RST = 8'h41;
	// Oscillator control field
	localparam int OSC_CUR_LSB = 12;
	// Clock monitor delay
	localparam int CLOCK_FAIL_MONITOR_W = 16;
	localparam logic [CLOCK_FAIL_MONITOR_W-1:0] CLOCK_FAIL_MONITOR_RST = 16'h0010;
	// Status fields
	localparam int ST_RST = 0;
	localparam int ST_CLK = 1;
	localparam int ST_MON = 2;
	localparam int ST_SEL_LSB = 4;
	localparam int ST_CAUSE_LSB = 8;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] OS_FRC = 3'h0;
	localparam logic [2:0] OS_FAST_RC_WITH_PLL = 3'h1;
	localparam logic [2:0] OS_PRI = 3'h2;
	localparam logic [2:0] OS_PRIPLL = 3'h3;
	localparam logic [2:0] OS_SECONDARY_OSCILLATOR = 3'h4;
	localparam logic [2:0] OS_LOW_POWER_RC_OSCILLATOR = 3'h5;
	localparam logic [2:0] OS_FAST_RC_DIVIDED = 3'h6;
	// Primary oscillator mode
	localparam logic [1:0] PM_EC = 2'h0;
	localparam logic [1:0] PM_XT = 2'h1;
	localparam logic [1:0] PM_HS = 2'h2;

	typedef enum logic [2:0] {CA_POR, CA_BOR, CA_PIN, CA_WDT, CA_SW} rcs_cause_t;
	typedef enum logic [1:0] {R_HOLD, R_START, R_WAIT, R_RUN} rcs_rst_t;
	typedef enum logic [2:0] {C_IDLE, C_RC, C_OST, C_LOCK, C_DONE} rcs_clk_t;
	typedef struct packed {
		rcs_clk_t first;
		logic lock;
		logic low_power_rc_oscillator;
	} rcs_plan_t;

endpackage

// >>> src/rcs_timer.sv
`timescale 1ns/1ps
module rcs_timer
	import rcs_pkg::*;
#(
	parameter int W = TMR_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic [W-1:0] load,
	// Status
	output logic done
);

	// Remaining cycles
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	// Load on start, else count down to zero and stop
	always_comb begin
		next_cnt = cnt;
		if (start) begin
			next_cnt = load;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Masked while loading so a stale zero never reads as expired
	assign done = (cnt == '0) && !start;

endmodule

// >>> src/rcs_seq_top.sv
`timescale 1ns/1ps
module rcs_seq_top
	import rcs_pkg::*;
#(
	parameter int POWER_UP_TIMER_CYC_P = POWER_UP_TIMER_CYC,
	parameter int POR_CYC = 1000,
	parameter int FRC_CYC = 200,
	parameter int LOW_POWER_RC_OSCILLATOR_CYC = 500
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// Register bus, write side
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// Register bus, read side
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Reset sources, high while held
	input wire logic RST_POR,
	input wire logic RST_BOR,
	input wire logic RST_PIN,
	input wire logic RST_WDT,
	input wire logic RST_SW,
	// Oscillator and PLL
	input wire logic OSC_TICK,
	input wire logic PLL_LOCK,
	// Outputs to core and clocks
	output logic SYS_RESET,
	output logic CORE_CLK_EN,
	output logic CLOCK_FAIL_MONITOR_EN,
	output logic [2:0] OSC_SEL,
	output logic PLL_EN
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	// Byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Highest priority cause among held pins
	function automatic rcs_cause_t pick(input logic [4:0] p);
		if (p[0]) return CA_POR;
		if (p[1]) return CA_BOR;
		if (p[2]) return CA_PIN;
		if (p[3]) return CA_WDT;
		return CA_SW;
	endfunction

	// First clock phase and PLL need for a reset cause and source
	function automatic rcs_plan_t plan_of(input rcs_cause_t c, input logic [2:0] s,
			input logic [1:0] pm, input logic two);
		rcs_plan_t p;
		p = '{first: C_DONE, lock: 1'b0, low_power_rc_oscillator: 1'b0};
		p.lock = (s == OS_FAST_RC_WITH_PLL) || (s == OS_PRIPLL);
		// no clock delay on other resets
		if (c != CA_POR && c != CA_BOR) begin
			p.first = C_DONE;
		end else if (two && (s == OS_PRI || s == OS_PRIPLL)) begin
			p.first = C_RC;
		// brown-out crystal PLL uses RC plus lock
		end else if (c == CA_BOR && s == OS_PRIPLL && pm != PM_EC) begin
			p.first = C_RC;
		end else begin
			case (s)
				OS_FRC, OS_FAST_RC_DIVIDED, OS_FAST_RC_WITH_PLL: p.first = C_RC;
				OS_LOW_POWER_RC_OSCILLATOR: begin
					p.first = C_RC;
					p.low_power_rc_oscillator = 1'b1;
				end
				OS_PRI: p.first = (pm == PM_EC) ? C_DONE : C_OST;
				OS_PRIPLL: p.first = (pm == PM_EC) ? C_LOCK : C_OST;
				OS_SECONDARY_OSCILLATOR: p.first = C_OST;
				default: p.first = C_DONE;
			endcase
		end
		return p;
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Bits: 0..4 reset pins, 5 oscillator tick, 6 PLL lock
	logic [6:0] sync1;
	logic [6:0] sync2;
	logic tick_d;

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			sync1 <= '0;
			sync2 <= '0;
			tick_d <= 1'b0;
		end else begin
			sync1 <= {PLL_LOCK, OSC_TICK, RST_SW, RST_WDT, RST_PIN, RST_BOR, RST_POR};
			sync2 <= sync1;
			tick_d <= sync2[5];
		end
	end

	logic any_pin;
	logic tick;
	logic pll_ok;
	assign any_pin = |sync2[4:0];
	assign tick = sync2[5] && !tick_d;
	assign pll_ok = sync2[6];

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	logic aw_held, w_held, wr_go;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic next_aw_held, next_w_held, next_awready, next_wready, next_bvalid, next_rvalid;
	logic next_arready;
	logic [ADDR_W-1:0] next_aw_addr;
	logic [31:0] next_w_data, next_rdata, rd_word;
	logic [3:0] next_w_strb;
	logic [1:0] next_bresp, next_rresp;
	logic wr_ok;
	logic rd_ok;

	// Configuration and control state
	logic [CFG_W-1:0] cfg, next_cfg;
	logic [2:0] cur_osc, next_cur_osc;
	logic [CLOCK_FAIL_MONITOR_W-1:0] clock_fail_monitor_dly, next_clock_fail_monitor_dly;
	// Sequencer state
	rcs_rst_t rst_st, next_rst_st;
	rcs_clk_t cph, next_cph;
	rcs_cause_t cause, next_cause;
	logic [2:0] sel, next_sel, sel_pick;
	logic use_pll, next_use_pll;
	logic [OST_W-1:0] ost_cnt, next_ost_cnt;
	logic [TMR_W-1:0] wait_cnt, next_wait_cnt, rst_load, power_up_timer_load;
	rcs_plan_t plan;
	logic rst_done, clk_done, mon_done;

	assign wr_go = aw_held && w_held && !BVALID;
	assign wr_ok = aw_addr == ADDR_CFG || aw_addr == ADDR_OSC || aw_addr == ADDR_CLOCK_FAIL_MONITOR;
	// Read decode looks at the read address only, never at a held write
	assign rd_ok = ARADDR == ADDR_CFG || ARADDR == ADDR_OSC || ARADDR == ADDR_CLOCK_FAIL_MONITOR
		|| ARADDR == ADDR_STAT;

	// Read mux; reserved bits read zero
	always_comb begin
		rd_word = '0;
		case (ARADDR)
			ADDR_CFG: rd_word[CFG_W-1:0] = cfg;
			ADDR_OSC: rd_word[OSC_CUR_LSB +: 3] = cur_osc;
			ADDR_CLOCK_FAIL_MONITOR: rd_word[CLOCK_FAIL_MONITOR_W-1:0] = clock_fail_monitor_dly;
			ADDR_STAT: begin
				rd_word[ST_RST] = SYS_RESET;
				rd_word[ST_CLK] = CORE_CLK_EN;
				rd_word[ST_MON] = CLOCK_FAIL_MONITOR_EN;
				rd_word[ST_SEL_LSB +: 3] = sel;
				rd_word[ST_CAUSE_LSB +: 3] = cause;
			end
			default: rd_word = '0;
		endcase
	end

	// Handshakes: address and data taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = BVALID;
		next_bresp = BRESP;
		next_rvalid = RVALID;
		next_rdata = RDATA;
		next_rresp = RRESP;
		if (AWVALID && AWREADY) begin
			next_aw_held = 1'b1;
			next_aw_addr = AWADDR;
		end
		if (WVALID && WREADY) begin
			next_w_held = 1'b1;
			next_w_data = WDATA;
			next_w_strb = WSTRB;
		end
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (BVALID && BREADY) begin
			next_bvalid = 1'b0;
		end
		if (ARVALID && ARREADY) begin
			next_rvalid = 1'b1;
			next_rdata = rd_word;
			next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			next_rvalid = 1'b0;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= RESP_OKAY;
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= '0;
			RRESP <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			AWREADY <= next_awready;
			WREADY <= next_wready;
			BVALID <= next_bvalid;
			BRESP <= next_bresp;
			ARREADY <= next_arready;
			RVALID <= next_rvalid;
			RDATA <= next_rdata;
			RRESP <= next_rresp;
		end
	end

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	// Merged words, so the fields can be sliced out of a named net
	logic [31:0] wr_cfg_word;
	logic [31:0] wr_osc_word;
	logic [31:0] wr_mon_word;
	assign wr_cfg_word = merge(32'(cfg), w_data, w_strb);
	assign wr_osc_word = merge(32'(cur_osc) << OSC_CUR_LSB, w_data, w_strb);
	assign wr_mon_word = merge(32'(clock_fail_monitor_dly), w_data, w_strb);

	always_comb begin
		next_cfg = cfg;
		next_cur_osc = cur_osc;
		next_clock_fail_monitor_dly = clock_fail_monitor_dly;
		if (wr_go && aw_addr == ADDR_CFG) begin
			next_cfg = wr_cfg_word[CFG_W-1:0];
		end
		if (wr_go && aw_addr == ADDR_OSC) begin
			next_cur_osc = wr_osc_word[OSC_CUR_LSB +: 3];
		end
		if (wr_go && aw_addr == ADDR_CLOCK_FAIL_MONITOR) begin
			next_clock_fail_monitor_dly = wr_mon_word[CLOCK_FAIL_MONITOR_W-1:0];
		end
		// Hardware load beats a same-cycle software write
		if (rst_st == R_START) begin
			next_cur_osc = sel_pick;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			cfg <= CFG_RST;
			cur_osc <= '0;
			clock_fail_monitor_dly <= CLOCK_FAIL_MONITOR_RST;
		end else begin
			cfg <= next_cfg;
			cur_osc <= next_cur_osc;
			clock_fail_monitor_dly <= next_clock_fail_monitor_dly;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// source pick by cause
	assign sel_pick = (!cfg[CFG_CSW] || cause == CA_POR || cause == CA_BOR) ?
		cfg[CFG_SEL_LSB +: 3] : cur_osc;
	assign plan = plan_of(cause, sel_pick, cfg[CFG_PM_LSB +: 2], cfg[CFG_TWO]);
	assign power_up_timer_load = cfg[CFG_POWER_UP_TIMER] ? TMR_W'(POWER_UP_TIMER_CYC_P) : '0;

	always_comb begin
		case (cause)
			CA_POR: rst_load = TMR_W'(POR_CYC) + power_up_timer_load;
			CA_BOR: rst_load = power_up_timer_load;
			default: rst_load = '0;
		endcase
	end

	rcs_timer #(.W(TMR_W)) u_rst_tmr (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.start(rst_st == R_START),
		.load(rst_load),
		.done(rst_done)
	);

	rcs_timer #(.W(TMR_W)) u_clk_tmr (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.start(rst_st == R_START && plan.first == C_RC),
		.load(plan.low_power_rc_oscillator ? TMR_W'(LOW_POWER_RC_OSCILLATOR_CYC) : TMR_W'(FRC_CYC)),
		.done(clk_done)
	);

	rcs_timer #(.W(TMR_W)) u_mon_tmr (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.start(rst_st == R_WAIT && rst_done),
		.load(TMR_W'(clock_fail_monitor_dly)),
		.done(mon_done)
	);

	// Clock phase and reset phase run side by side
	always_comb begin
		next_rst_st = rst_st;
		next_cph = cph;
		next_cause = cause;
		next_sel = sel;
		next_use_pll = use_pll;
		next_ost_cnt = ost_cnt;
		next_wait_cnt = wait_cnt;
		case (cph)
			C_RC: if (clk_done) begin
				next_cph = use_pll ? C_LOCK : C_DONE;
			end
			C_OST: if (tick) begin
				next_ost_cnt = ost_cnt + 1'b1;
				if (ost_cnt == OST_LAST) begin
					next_cph = use_pll ? C_LOCK : C_DONE;
				end
			end
			C_LOCK: if (pll_ok) begin
				next_cph = C_DONE;
			end
			default: next_cph = cph;
		endcase
		case (rst_st)
			R_HOLD: next_rst_st = R_START;
			R_START: begin
				next_rst_st = R_WAIT;
				next_sel = sel_pick;
				next_use_pll = plan.lock;
				next_cph = plan.first;
				next_ost_cnt = '0;
				next_wait_cnt = '0;
			end
			R_WAIT: if (rst_done) begin
				next_rst_st = R_RUN;
			end else begin
				next_wait_cnt = wait_cnt + 1'b1;
			end
			R_RUN: next_rst_st = R_RUN;
			default: next_rst_st = R_HOLD;
		endcase
		// Any held source restarts the whole sequence
		if (any_pin) begin
			next_rst_st = R_HOLD;
			next_cph = C_IDLE;
			next_cause = pick(sync2[4:0]);
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rst_st <= R_HOLD;
			cph <= C_IDLE;
			cause <= CA_POR;
			sel <= '0;
			use_pll <= 1'b0;
			ost_cnt <= '0;
			wait_cnt <= '0;
			SYS_RESET <= 1'b1;
			CORE_CLK_EN <= 1'b0;
			CLOCK_FAIL_MONITOR_EN <= 1'b0;
			OSC_SEL <= '0;
			PLL_EN <= 1'b0;
		end else begin
			rst_st <= next_rst_st;
			cph <= next_cph;
			cause <= next_cause;
			sel <= next_sel;
			use_pll <= next_use_pll;
			ost_cnt <= next_ost_cnt;
			wait_cnt <= next_wait_cnt;
			SYS_RESET <= next_rst_st != R_RUN;
			// core clock gated until clock ready
			CORE_CLK_EN <= next_rst_st == R_RUN && next_cph == C_DONE;
			CLOCK_FAIL_MONITOR_EN <= next_rst_st == R_RUN && rst_st == R_RUN && mon_done;
			OSC_SEL <= next_sel;
			PLL_EN <= next_use_pll && next_rst_st != R_HOLD;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	sequence s_start_other;
		rst_st == R_START && cause != CA_POR && cause != CA_BOR;
	endsequence

	release_on_expiry_a: assert property ($fell(SYS_RESET) |-> $past(rst_done))
		else $error("system reset released before delay expired");
	por_delay_a: assert property (rst_st == R_WAIT && rst_done && cause == CA_POR
		|-> wait_cnt == TMR_W'(POR_CYC) + power_up_timer_load)
		else $error("power-on reset delay length wrong");
	bor_delay_a: assert property (rst_st == R_WAIT && rst_done && cause == CA_BOR
		|-> wait_cnt == power_up_timer_load)
		else $error("brown-out reset delay length wrong");
	other_nodelay_a: assert property (s_start_other ##1 !any_pin
		|-> rst_done && cph == C_DONE)
		else $error("delay applied to other reset type");
	sel_config_a: assert property (rst_st == R_START && !any_pin
		&& (!cfg[CFG_CSW] || cause == CA_POR || cause == CA_BOR)
		|=> sel == $past(cfg[CFG_SEL_LSB +: 3]))
		else $error("configured source not taken");
	sel_keep_a: assert property (rst_st == R_START && cause != CA_POR
		&& cause != CA_BOR && cfg[CFG_CSW] && !any_pin
		|=> sel == $past(cur_osc))
		else $error("current oscillator not kept");
	ost_count_a: assert property ($past(cph == C_OST) && (cph == C_LOCK || cph == C_DONE)
		|-> $past(ost_cnt) == OST_LAST && $past(tick))
		else $error("start-up timer left early");
	clk_gate_a: assert property (CORE_CLK_EN |-> !SYS_RESET && cph == C_DONE)
		else $error("core clock enabled too soon");
	mon_start_a: assert property ($rose(CLOCK_FAIL_MONITOR_EN) |-> $past(!SYS_RESET, 2))
		else $error("monitor started before release");

endmodule

// >>> verif/rcs_osc_model.sv
`timescale 1ns/1ps
module rcs_osc_model #(
	parameter int HALF_CYC = 3,
	parameter int LOCK_CYC = 40
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// From the sequencer
	input wire logic pll_en,
	// To the sequencer
	output logic osc_tick,
	output logic pll_lock
);
	int half_cnt; // Cycles into this oscillator half period
	int lock_cnt; // Cycles since the PLL was enabled

	// ---------------------------------------------------------------
	// Oscillator and PLL
	// ---------------------------------------------------------------
	// periods and lock
	// Crystal runs free; lock drops at once when the PLL is disabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt <= 0;
			osc_tick <= 1'b0;
			lock_cnt <= 0;
			pll_lock <= 1'b0;
		end else begin
			half_cnt <= (half_cnt == HALF_CYC - 1) ? 0 : half_cnt + 1;
			if (half_cnt == HALF_CYC - 1)
				osc_tick <= ~osc_tick;
			lock_cnt <= pll_en ? lock_cnt + 1 : 0;
			pll_lock <= pll_en && (lock_cnt >= LOCK_CYC);
		end
	end
endmodule

// >>> verif/rcs_seq_top_tb.sv
`timescale 1ns/1ps
module rcs_seq_top_tb;
	import rcs_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic clk_sys = 1'b0; // System clock
	logic rst_n = 1'b0; // Bench reset
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF; // Byte lanes of a write
	logic [4:0] rst_pins = '0; // POR, brown-out, pin, watchdog, software
	logic awready, wready, bvalid, arready, rvalid, sys_reset, core_clk_en, clock_fail_monitor_en, pll_en;
	logic osc_tick, pll_lock;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd;
	logic [2:0] osc_sel;
	int err_total = 0, n_checks = 0, viol = 0, k;

	always #5 clk_sys = ~clk_sys;

	rcs_seq_top #(.POWER_UP_TIMER_CYC_P(50), .POR_CYC(20), .FRC_CYC(10), .LOW_POWER_RC_OSCILLATOR_CYC(15)) rcs_seq_top_inst (
		.CLK_SYS(clk_sys), .RSTN(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.RST_POR(rst_pins[0]), .RST_BOR(rst_pins[1]), .RST_PIN(rst_pins[2]),
		.RST_WDT(rst_pins[3]), .RST_SW(rst_pins[4]), .OSC_TICK(osc_tick), .PLL_LOCK(pll_lock),
		.SYS_RESET(sys_reset), .CORE_CLK_EN(core_clk_en), .CLOCK_FAIL_MONITOR_EN(clock_fail_monitor_en), .OSC_SEL(osc_sel),
		.PLL_EN(pll_en)
	);
	rcs_osc_model rcs_osc_model_inst (.clk(clk_sys), .rst_n(rst_n), .pll_en(pll_en),
		.osc_tick(osc_tick), .pll_lock(pll_lock));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Verdict and end of run
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Count within a window, since sync stages blur the exact edge
	task automatic rng(input int v, input int lo, input int hi);
		check({31'h0, (v >= lo && v <= hi)}, 32'h0000_0001);
	endtask

	// One clock with a bounded wait budget
	task automatic step(inout int n);
		@(posedge clk_sys);
		n++;
		if (n > 9000) begin
			err_total++;
			stop_test();
		end
	endtask

	// Bus write; address and data offered together, released when taken
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			step(n);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		check({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask

	// Bus read; data and response taken at the answering edge
	task automatic axr(input logic [ADDR_W-1:0] a, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			step(n);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		check({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
	endtask

	// Pulse one reset source, then time release, clock and monitor
	task automatic run(input logic [7:0] c, input int src, input int rlo, input int rhi,
		input int clo, input int chi, input int mlo, input int mhi, input logic [2:0] s);
		int n, tr, tc, tm;
		tr = -1;
		tc = -1;
		tm = -1;
		n = 0;
		viol = 0;
		axw(ADDR_CFG, {24'h00_0000, c}, RESP_OKAY);
		rst_pins[src] <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rst_pins <= '0;
		while (tc < 0 || tm < 0) begin
			step(n);
			if (tr < 0 && sys_reset === 1'b0)
				tr = n;
			if (tc < 0 && core_clk_en === 1'b1)
				tc = n;
			if (tm < 0 && clock_fail_monitor_en === 1'b1)
				tm = n;
			if (sys_reset !== 1'b0 && (core_clk_en !== 1'b0 || clock_fail_monitor_en !== 1'b0))
				viol++;
		end
		rng(tr, rlo, rhi);
		rng(tc, clo, chi);
		rng(tm - tr, mlo, mhi);
		check(viol, 0);
		check({29'h0, osc_sel}, {29'h0, s});
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		k = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		while (sys_reset !== 1'b0)
			step(k);
		rng(k, 70, 78);
		axr(ADDR_CFG, RESP_OKAY);
		check(rd, 32'h0000_0041);
		axr(ADDR_CLOCK_FAIL_MONITOR, RESP_OKAY);
		check(rd, 32'h0000_0010);
		axr(8'h10, RESP_SLVERR);
		check(rd, 32'h0000_0000);
		axw(ADDR_STAT, 32'h0000_0000, RESP_SLVERR);
		axw(8'h10, 32'h0000_0001, RESP_SLVERR);
		// Power-on cases, power-up timer on then off, per clock source
		run(8'h41, 0, 72, 80, 72, 82, 16, 20, 3'h0);
		run(8'h05, 0, 22, 30, 22, 32, 16, 20, 3'h2);
		run(8'h07, 0, 22, 30, 42, 75, 16, 20, 3'h3);
		run(8'h03, 0, 22, 30, 42, 80, 16, 20, 3'h1);
		run(8'h15, 0, 22, 30, 6140, 6200, 16, 20, 3'h2);
		run(8'h27, 0, 22, 30, 6140, 6220, 16, 20, 3'h3);
		run(8'h09, 0, 22, 30, 6140, 6200, 16, 20, 3'h4);
		run(8'h95, 0, 22, 30, 22, 40, 16, 20, 3'h2);
		// Brown-out cases
		run(8'h17, 1, 1, 10, 42, 80, 16, 20, 3'h3);
		run(8'h4B, 1, 52, 60, 52, 62, 16, 20, 3'h5);
		axr(ADDR_STAT, RESP_OKAY);
		check({26'h0, rd[10:8], rd[6:4]}, 32'h0000_000D);
		axr(ADDR_OSC, RESP_OKAY);
		check({29'h0, rd[14:12]}, 32'h0000_0005);
		// Pin, watchdog and software resets keep current source and add no delay
		run(8'h15, 2, 1, 10, 1, 12, 16, 20, 3'h5);
		axw(ADDR_OSC, 32'h0000_6000, RESP_OKAY);
		run(8'h15, 3, 1, 10, 1, 12, 16, 20, 3'h6);
		run(8'h15, 4, 1, 10, 1, 12, 16, 20, 3'h6);
		// Switching off: configured source whatever the cause
		run(8'h14, 2, 1, 10, 1, 12, 16, 20, 3'h2);
		// Single byte lane lands alone
		wstrb <= 4'h2;
		axw(ADDR_CLOCK_FAIL_MONITOR, 32'h0000_3355, RESP_OKAY);
		wstrb <= 4'hF;
		axr(ADDR_CLOCK_FAIL_MONITOR, RESP_OKAY);
		check(rd, 32'h0000_3310);
		// Longer monitor delay
		axw(ADDR_CLOCK_FAIL_MONITOR, 32'h0000_0020, RESP_OKAY);
		run(8'h05, 0, 22, 30, 22, 32, 32, 36, 3'h2);
		stop_test();
	end
endmodule
